// ---- plci_pkg.sv ----
// package for the parameter-load host controller
// assumes a 50 MHz clock and a 32-bit classic wishbone register port
package plci_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int SETTLE_MS = 20;
    localparam int SETTLE_SCANS = 3;
    localparam int SETTLE_CYC = (CLK_HZ / 1000) * SETTLE_MS;
    localparam int SCAN_CYC = 700_000;
    localparam int FAULT_WAIT_CYC = 4;
    // ----------------------------------------
    // command block contents
    // ----------------------------------------
    localparam logic [15:0] CB_HDR_LEN = 16'h0004;
    localparam logic [15:0] CB_CMD_LOAD = 16'he501;
    localparam logic [15:0] CB_DATA_SIZE = 16'h0044;
    localparam logic [15:0] CB_MEM_REG = 16'h0008;
    localparam logic [15:0] CB_PCOUNT = 16'h0010;
    localparam logic [5:0] CB_FIRST = 6'h01;
    localparam logic [5:0] CB_DATA0 = 6'h0d;
    localparam logic [5:0] CB_LAST = 6'h2c;
    localparam logic [15:0] IMM_RET_PARAM = 16'h1840;
    localparam logic [7:0] MAX_START = 8'hf0;
    localparam int NPARAM = 16;
    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_TARGET = 8'h08;
    localparam logic [7:0] A_START = 8'h0c;
    localparam logic [7:0] A_VSEL = 8'h10;
    localparam logic [7:0] A_OFS = 8'h14;
    localparam logic [7:0] A_IST = 8'h18;
    localparam logic [7:0] A_IMASK = 8'h1c;
    localparam logic [7:0] A_RET = 8'h20;
    localparam logic [7:0] A_TAB = 8'h40;
    // ctrl bits
    localparam int C_LOAD = 0;
    localparam int C_VERIFY = 1;
    localparam int C_CLRINH = 2;
    // status / interrupt bits
    localparam int S_BUSY = 0;
    localparam int S_FAULT = 1;
    localparam int S_MISM = 2;
    localparam int S_RANGE = 3;
    localparam int E_LDONE = 0;
    localparam int E_FAULT = 1;
    localparam int E_VPASS = 2;
    localparam int E_VFAIL = 3;
    localparam int NEV = 4;
    localparam logic [31:0] RST_TARGET = 32'h0000_0007;
    localparam logic [31:0] RST_OFS = 32'h00cd_00c2;
    typedef enum logic [2:0] {PLCI_IDLE, PLCI_SEND, PLCI_FLTW, PLCI_IMM, PLCI_SETTLE} plci_state_e;
endpackage

// ---- plci_host.sv ----
// host controller: builds the parameter-load request block and the
// select-return-data immediate command, then checks the returned value
// assumes device link pins synchronous to clk_i; software on classic wishbone
//
// Contract
// R1 - load request carries command code e501 hex
// R2 - data size field is 68 bytes
// R3 - parameter count field is 16
// R4 - parameter data memory type code is 8, register memory
// R5 - data start given zero-based, register number minus one
// R6 - device stores double words into ascending parameters from the start
// R7 - parameters are 32 bits, low word first, then high word
// R8 - request addressed by rack and slot, with first block word location
// R9 - task selector of every request is zero
// R10 - immediate command low byte 40 hex selects return data
// R11 - high byte 18 hex selects parameter data, word 1840
// R12 - second immediate word is the parameter number to return
// R13 - returned value used only after 3 scans or 20 ms, longer one
// R14 - compare returned value with sent value, inhibit motion on mismatch
// R15 - wait flag, idle timeout and max time fields are zero
// R16 - starting parameter 0 to 255, at most 240 for sixteen
// R17 - device rejects bad requests and reports a fault
// R18 - device updates both returned halves together
//
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module plci_host
    import plci_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_CYC,
    parameter int SCAN_CYCLES = SCAN_CYC
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    output logic host_comm_request_o,
    output logic [15:0] target_rack_slot_id_o,
    output logic [15:0] cb_location_o,
    output logic [7:0] comm_task_o,
    output logic cb_valid_o,
    output logic [5:0] cb_index_o,
    output logic [15:0] cb_word_o,
    input wire logic request_fault_output_i,
    output logic [31:0] host_output_word_image_o,
    input wire logic [31:0] host_input_word_image_i,
    output logic motion_inhibit_o
);
    import plci_pkg::*;

    function automatic int imax(input int a, input int b);
        imax = (a > b) ? a : b;
    endfunction

    localparam int WAIT_CYC = imax(SETTLE_SCANS * SCAN_CYCLES, SETTLE_CYCLES); // R13
    localparam int CW = $clog2(WAIT_CYC + 1);

    // refuse settle counts that the wait counter cannot hold
    if (SETTLE_CYCLES < 1 || SCAN_CYCLES < 1 || CW > 31)
    begin : g_bad_settle
        $error("plci_host: bad settle parameters");
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // byte-lane merge of a wishbone write
    function automatic logic [31:0] bmerge(input logic [31:0] o, input logic [31:0] n,
                                           input logic [3:0] s);
        bmerge = o;
        for (int b = 0; b < 4; b++)
        begin
            if (s[b])
                bmerge[b*8 +: 8] = n[b*8 +: 8];
        end
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    plci_state_e st, next_st;
    logic [31:0] tab [NPARAM];
    logic [31:0] next_tab [NPARAM];
    logic [31:0] target, next_target;
    logic [7:0] start, next_start;
    logic [7:0] vsel, next_vsel;
    logic [31:0] ofs, next_ofs;
    logic [NEV-1:0] ist, next_ist, imask, next_imask;
    logic [31:0] ret, next_ret;
    logic fault, next_fault, mism, next_mism, range_err, next_range_err;
    logic [CW-1:0] cnt, next_cnt;
    logic [5:0] idx, next_idx;
    logic [31:0] next_dat;
    logic next_ack, next_irq, next_req, next_cbv, next_inh;
    logic [15:0] next_cbw;
    logic [31:0] next_aq;
    logic act, wr, rd;
    logic [NEV-1:0] ev;
    logic [4:0] k;
    logic [7:0] vdiff;

    // command block word for a given word number, 1 based
    function automatic logic [15:0] cbword(input logic [5:0] i);
        logic [4:0] d;
        logic [31:0] v;
        d = 5'(i - CB_DATA0);
        v = tab[d[4:1]];
        case (i)
            6'h01: cbword = CB_HDR_LEN;
            6'h02: cbword = 16'h0000; // R15
            6'h03: cbword = CB_MEM_REG;
            6'h04: cbword = ofs[15:0] - 16'h0001; // R5
            6'h05, 6'h06: cbword = 16'h0000; // R15
            6'h07: cbword = CB_CMD_LOAD; // R1
            6'h08: cbword = CB_DATA_SIZE; // R2
            6'h09: cbword = CB_MEM_REG; // R4
            6'h0a: cbword = ofs[31:16] - 16'h0001; // R5
            6'h0b: cbword = {8'h00, start}; // R16
            6'h0c: cbword = CB_PCOUNT; // R3
            default: cbword = d[0] ? v[31:16] : v[15:0]; // R6 R7
        endcase
    endfunction

    // ----------------------------------------
    // register bus and sequencer
    // ----------------------------------------
    // bus access completes on the edge where ack is high
    always_comb
    begin
        act = wb_cyc_i && wb_stb_i && wb_ack_o;
        wr = act && wb_we_i;
        rd = act && !wb_we_i;
        next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
        next_tab = tab;
        next_target = target;
        next_start = start;
        next_vsel = vsel;
        next_ofs = ofs;
        next_imask = imask;
        next_st = st;
        next_cnt = cnt;
        next_idx = idx;
        next_ret = ret;
        next_fault = fault;
        next_mism = mism;
        next_range_err = range_err;
        next_inh = motion_inhibit_o;
        next_req = 1'b0;
        next_cbv = 1'b0;
        next_cbw = cb_word_o;
        next_aq = host_output_word_image_o;
        ev = '0;
        vdiff = vsel - start;
        k = vdiff[4:0];
        // read data, registered with ack
        next_dat = 32'h0000_0000;
        if (wb_adr_i >= A_TAB)
            next_dat = tab[wb_adr_i[5:2]];
        else
        begin
            case (wb_adr_i)
                A_STAT: next_dat = {27'h0, motion_inhibit_o, range_err, mism, fault,
                                    st != PLCI_IDLE};
                A_TARGET: next_dat = target;
                A_START: next_dat = {24'h0, start};
                A_VSEL: next_dat = {24'h0, vsel};
                A_OFS: next_dat = ofs;
                A_IST: next_dat = {28'h0, ist};
                A_IMASK: next_dat = {28'h0, imask};
                A_RET: next_dat = ret;
                default: next_dat = 32'h0000_0000;
            endcase
        end
        if (!next_ack)
            next_dat = 32'h0000_0000;
        // register writes
        if (wr)
        begin
            if (wb_adr_i >= A_TAB)
                next_tab[wb_adr_i[5:2]] = bmerge(tab[wb_adr_i[5:2]], wb_dat_i, wb_sel_i);
            else
            begin
                case (wb_adr_i)
                    A_TARGET: next_target = bmerge(target, wb_dat_i, wb_sel_i);
                    A_START: next_start = wb_sel_i[0] ? wb_dat_i[7:0] : start;
                    A_VSEL: next_vsel = wb_sel_i[0] ? wb_dat_i[7:0] : vsel;
                    A_OFS: next_ofs = bmerge(ofs, wb_dat_i, wb_sel_i);
                    A_IMASK: next_imask = wb_sel_i[0] ? wb_dat_i[NEV-1:0] : imask;
                    A_CTRL:
                    begin
                        if (wb_sel_i[0] && wb_dat_i[C_CLRINH])
                            next_inh = 1'b0;
                    end
                    default: next_inh = motion_inhibit_o;
                endcase
            end
        end
        // sequencer
        case (st)
            PLCI_IDLE:
            begin
                if (wr && wb_adr_i == A_CTRL && wb_sel_i[0] && wb_dat_i[C_LOAD])
                begin
                    if (start > MAX_START) // R16
                        next_range_err = 1'b1;
                    else
                    begin
                        next_range_err = 1'b0;
                        next_fault = 1'b0;
                        next_req = 1'b1;
                        next_idx = CB_FIRST;
                        next_st = PLCI_SEND;
                    end
                end
                else if (wr && wb_adr_i == A_CTRL && wb_sel_i[0] && wb_dat_i[C_VERIFY])
                begin
                    next_aq = {8'h00, vsel, IMM_RET_PARAM}; // R10 R11 R12
                    next_cnt = '0;
                    next_st = PLCI_IMM;
                end
            end
            PLCI_SEND:
            begin
                next_cbv = 1'b1;
                next_cbw = cbword(idx);
                next_idx = idx + 6'h01;
                if (idx == CB_LAST)
                begin
                    next_cnt = '0;
                    next_st = PLCI_FLTW;
                end
            end
            PLCI_FLTW:
            begin
                next_cnt = cnt + 1'b1;
                if (request_fault_output_i) // R17
                begin
                    next_fault = 1'b1;
                    ev[E_FAULT] = 1'b1;
                    next_st = PLCI_IDLE;
                end
                else if (cnt == CW'(FAULT_WAIT_CYC - 1))
                begin
                    ev[E_LDONE] = 1'b1;
                    next_st = PLCI_IDLE;
                end
            end
            PLCI_IMM:
            begin
                next_cnt = cnt + 1'b1;
                if (cnt == CW'(WAIT_CYC - 1)) // R13
                    next_st = PLCI_SETTLE;
            end
            PLCI_SETTLE:
            begin
                next_ret = host_input_word_image_i; // R18
                next_st = PLCI_IDLE;
                if (vdiff < 8'(NPARAM) && host_input_word_image_i == tab[k[3:0]]) // R14
                begin
                    next_mism = 1'b0;
                    ev[E_VPASS] = 1'b1;
                end
                else
                begin
                    next_mism = 1'b1;
                    next_inh = 1'b1; // R14
                    ev[E_VFAIL] = 1'b1;
                end
            end
            default: next_st = PLCI_IDLE;
        endcase
        // read clears only the bits it reported, so an event landing as the
        // read data is latched is not lost; a new event wins
        next_ist = ((rd && wb_adr_i == A_IST) ? (ist & ~wb_dat_o[NEV-1:0]) : ist) | ev;
        next_irq = |(next_ist & next_imask);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st <= PLCI_IDLE;
            for (int i = 0; i < NPARAM; i++)
                tab[i] <= 32'h0000_0000;
            target <= RST_TARGET;
            start <= 8'h00;
            vsel <= 8'h00;
            ofs <= RST_OFS;
            ist <= '0;
            imask <= '0;
            ret <= 32'h0000_0000;
            fault <= 1'b0;
            mism <= 1'b0;
            range_err <= 1'b0;
            cnt <= '0;
            idx <= CB_FIRST;
            wb_dat_o <= 32'h0000_0000;
            wb_ack_o <= 1'b0;
            irq_o <= 1'b0;
            host_comm_request_o <= 1'b0;
            target_rack_slot_id_o <= 16'h0000;
            cb_location_o <= 16'h0000;
            comm_task_o <= 8'h00;
            cb_valid_o <= 1'b0;
            cb_index_o <= 6'h00;
            cb_word_o <= 16'h0000;
            host_output_word_image_o <= 32'h0000_0000;
            motion_inhibit_o <= 1'b0;
        end
        else
        begin
            st <= next_st;
            tab <= next_tab;
            target <= next_target;
            start <= next_start;
            vsel <= next_vsel;
            ofs <= next_ofs;
            ist <= next_ist;
            imask <= next_imask;
            ret <= next_ret;
            fault <= next_fault;
            mism <= next_mism;
            range_err <= next_range_err;
            cnt <= next_cnt;
            idx <= next_idx;
            wb_dat_o <= next_dat;
            wb_ack_o <= next_ack;
            irq_o <= next_irq;
            host_comm_request_o <= next_req;
            target_rack_slot_id_o <= target[15:0]; // R8
            cb_location_o <= target[31:16]; // R8
            comm_task_o <= 8'h00; // R9
            cb_valid_o <= next_cbv;
            cb_index_o <= idx;
            cb_word_o <= next_cbw;
            host_output_word_image_o <= next_aq;
            motion_inhibit_o <= next_inh;
        end
    end
endmodule

// ---- plci_host_chk.sv ----
// checker for the port behaviour of plci_host
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/1ps
module plci_host_chk
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic host_comm_request_o,
    input wire logic cb_valid_o,
    input wire logic [5:0] cb_index_o,
    input wire logic [15:0] cb_word_o,
    input wire logic [7:0] comm_task_o,
    input wire logic [31:0] host_output_word_image_o
);
    // ----------------------------------------
    // clocking and block steps
    // ----------------------------------------
    default clocking cb_clk @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // header length word then a zero wait flag
    sequence s_head;
        cb_valid_o && cb_index_o == 6'h01 && cb_word_o == 16'h0004 ##1
        cb_valid_o && cb_index_o == 6'h02 && cb_word_o == 16'h0000;
    endsequence
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    a_ack_answers_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    a_req_starts_block: assert property (host_comm_request_o |=> s_head)
        else $error("block start wrong");
    a_word_ascends: assert property (cb_valid_o && cb_index_o < 6'd44 |=>
        cb_valid_o && cb_index_o == $past(cb_index_o) + 6'h01)
        else $error("word order broken");
    a_block_end: assert property (cb_valid_o && cb_index_o == 6'd44 |=> !cb_valid_o[*4])
        else $error("words after block end");
    a_cmd_code: assert property (cb_valid_o && cb_index_o == 6'd7 |-> cb_word_o == 16'he501)
        else $error("command code wrong");
    a_size_count: assert property (cb_valid_o && cb_index_o == 6'd8 |->
        cb_word_o == 16'h0044 ##4 cb_word_o == 16'h0010)
        else $error("size or count wrong");
    a_mem_type: assert property (cb_valid_o && cb_index_o == 6'd9 |-> cb_word_o == 16'h0008)
        else $error("memory type wrong");
    a_unused_zero: assert property (cb_valid_o && cb_index_o == 6'd5 |->
        cb_word_o == 16'h0 ##1 cb_word_o == 16'h0)
        else $error("unused fields not zero");
    a_task_zero: assert property (comm_task_o == 8'h00)
        else $error("task selector not zero");
    a_image_cmd: assert property ($changed(host_output_word_image_o) |->
        host_output_word_image_o[15:0] == 16'h1840 && host_output_word_image_o[31:24] == 8'h0)
        else $error("immediate command wrong");
endmodule
bind plci_host plci_host_chk chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .host_comm_request_o(host_comm_request_o),
    .cb_valid_o(cb_valid_o), .cb_index_o(cb_index_o), .cb_word_o(cb_word_o),
    .comm_task_o(comm_task_o), .host_output_word_image_o(host_output_word_image_o));

// ---- plci_dev_model.sv ----
// model of the device: takes the command block, keeps the parameter table
// and answers the return-data command; assumes host strobes on clk_i
`timescale 1ns/1ps
module plci_dev_model
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cb_valid_i,
    input wire logic [5:0] cb_index_i,
    input wire logic [15:0] cb_word_i,
    input wire logic [31:0] image_i,
    input wire logic bad_i,
    input wire logic corrupt_i,
    output logic fault_o,
    output logic [31:0] ret_o
);
    logic [15:0] blk [1:44];
    logic [31:0] param [0:255];
    // cycles the command must stand before the answer lands, just short of
    // the bench's shortened host wait so an early sample sees stale data
    localparam int LAG = 6;
    logic [31:0] img1;
    int age;
    int flt;
    assign fault_o = flt > 0;
    // ----------------------------------------
    // block capture, checks, table store, answer
    // ----------------------------------------
    always @(posedge clk_i)
    begin
        img1 <= image_i;
        // count how long the immediate command has stood unchanged
        if (rst_i || image_i !== img1)
            age <= 0;
        else if (age < LAG)
            age <= age + 1;
        flt <= rst_i ? 0 : (flt > 0 ? flt - 1 : 0);
        if (cb_valid_i)
            blk[cb_index_i] <= cb_word_i;
        // a bad block raises the fault level across the host's window
        if (cb_valid_i && cb_index_i == 6'd44)
        begin
            if (blk[7] != 16'he501 || blk[8] != 16'h0044 || blk[12] != 16'h0010 || bad_i)
                flt <= 6;
            else
                for (int n = 0; n < 16; n++)
                    param[8'(blk[11] + n)] <= {n == 15 ? cb_word_i : blk[14 + 2 * n], blk[13 + 2 * n]};
        end
        // whole double word swapped in at once, only after the command settled
        if (rst_i)
            ret_o <= 32'h0;
        else if (img1[15:0] == 16'h1840 && age >= LAG)
            ret_o <= param[img1[23:16]] ^ {31'h0, corrupt_i};
    end
endmodule

// ---- plci_host_tb.sv ----
// self-checking bench for plci_host against the device model
// assumes shortened settle and scan counts so a run stays short
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module plci_host_tb;
    import plci_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, bad = 1'b0, corrupt = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf, sel = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, image, ret, q;
    logic wb_ack_o, irq_o, req, cb_valid, fault, inhibit;
    logic [15:0] rs_id, cb_loc, cb_word;
    logic [5:0] cb_index;
    logic [7:0] task_no, st;
    logic [15:0] cbw [1:44];
    logic [31:0] tab [0:15];
    int num_errors = 0, tests_run = 0, nreq = 0, k, old;
    integer seed = 32'h0e5c;
    always #10 clk_i = ~clk_i;
    plci_host #(.SETTLE_CYCLES(8), .SCAN_CYCLES(2)) uut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .irq_o(irq_o), .host_comm_request_o(req), .target_rack_slot_id_o(rs_id),
        .cb_location_o(cb_loc), .comm_task_o(task_no), .cb_valid_o(cb_valid),
        .cb_index_o(cb_index), .cb_word_o(cb_word), .request_fault_output_i(fault),
        .host_output_word_image_o(image), .host_input_word_image_i(ret),
        .motion_inhibit_o(inhibit));
    plci_dev_model dev (.clk_i(clk_i), .rst_i(rst_i), .cb_valid_i(cb_valid),
        .cb_index_i(cb_index), .cb_word_i(cb_word), .image_i(image), .bad_i(bad),
        .corrupt_i(corrupt), .fault_o(fault), .ret_o(ret));
    // ----------------------------------------
    // block word and request capture
    // ----------------------------------------
    always @(posedge clk_i)
    begin
        if (cb_valid) cbw[cb_index] <= cb_word;
        if (req) nreq <= nreq + 1;
    end
    // ----------------------------------------
    // bus cycles and expectations
    // ----------------------------------------
    task automatic wb_io(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= sel;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 50) fail("ack");
    endtask
    task automatic fail(input string s);
        num_errors++;
        $display("unexpected %s exp done got timeout", s);
        final_report();
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 100; i++)
        begin
            wb_io(1'b0, A_STAT, 32'h0);
            if (q[S_BUSY] === 1'b0) return;
        end
        fail("busy");
    endtask
    task automatic load(input logic [7:0] s);
        st = s;
        for (int n = 0; n < 16; n++)
        begin
            tab[n] = $random(seed);
            wb_io(1'b1, A_TAB + 8'(4 * n), tab[n]);
        end
        wb_io(1'b1, A_START, {24'h0, s});
        wb_io(1'b1, A_CTRL, 32'h1);
        wait_idle();
    endtask
    task automatic verify(input int n, input logic flip);
        wb_io(1'b1, A_VSEL, {24'h0, st + 8'(n)});
        wb_io(1'b1, A_CTRL, 32'h2);
        wait_idle();
        `CHK("image", {8'h00, st + 8'(n), 16'h1840}, image)
        wb_io(1'b0, A_RET, 32'h0);
        `CHK("ret", tab[n] ^ {31'h0, flip}, q)
    endtask
    function automatic logic [15:0] cb_exp(input int i);
        case (i)
            1: return 16'h0004;
            2, 5, 6: return 16'h0000;
            3, 9: return 16'h0008;
            4: return RST_OFS[15:0] - 16'h1;
            7: return 16'he501;
            8: return 16'h0044;
            10: return RST_OFS[31:16] - 16'h1;
            11: return {8'h00, st};
            12: return 16'h0010;
            default: return i[0] ? tab[(i - 13) / 2][15:0] : tab[(i - 13) / 2][31:16];
        endcase
    endfunction
    task automatic final_report();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wb_io(1'b0, A_TARGET, 32'h0);
        `CHK("target", 32'h0000_0007, q)
        wb_io(1'b0, A_OFS, 32'h0);
        `CHK("ofs", 32'h00cd_00c2, q)
        wb_io(1'b0, 8'h3c, 32'h0);
        `CHK("unmapped", 32'h0, q)
        wb_io(1'b1, A_IMASK, 32'hf);
        wb_io(1'b1, A_TARGET, 32'h00c4_0007);
        $display("test reset done");
        for (k = 0; k < 3; k++)
        begin
            load(k == 0 ? 8'd0 : (k == 1 ? 8'd240 : 8'($unsigned($random(seed)) % 241)));
            `CHK("rack slot", 32'h00c4_0007, {cb_loc, rs_id})
            `CHK("task", 8'h00, task_no)
            `CHK("irq", 1'b1, irq_o)
            wb_io(1'b0, A_IST, 32'h0);
            `CHK("ist", 32'h1, q)
            repeat (2) @(posedge clk_i);
            `CHK("irq", 1'b0, irq_o)
            for (int i = 1; i <= 44; i++) `CHK("word", cb_exp(i), cbw[i])
            for (int n = 0; n < 16; n++) `CHK("param", tab[n], dev.param[st + n])
            verify(k * 7 + 1, 1'b0);
            wb_io(1'b0, A_IST, 32'h0);
            `CHK("ist", 32'h4, q)
            `CHK("inhibit", 1'b0, inhibit)
            $display("test load %0d done", k);
        end
        corrupt <= 1'b1;
        verify(3, 1'b1);
        `CHK("inhibit", 1'b1, inhibit)
        wb_io(1'b0, A_IST, 32'h0);
        `CHK("ist", 32'h8, q)
        wb_io(1'b1, A_CTRL, 32'h4);
        repeat (2) @(posedge clk_i);
        `CHK("inhibit", 1'b0, inhibit)
        corrupt <= 1'b0;
        wb_io(1'b1, A_IMASK, 32'h0);
        verify(0, 1'b0);
        `CHK("irq masked", 1'b0, irq_o)
        wb_io(1'b0, A_IST, 32'h0);
        `CHK("ist", 32'h4, q)
        wb_io(1'b1, A_IMASK, 32'hf);
        $display("test verify done");
        old = nreq;
        wb_io(1'b1, A_START, 32'h0000_00f1);
        wb_io(1'b1, A_CTRL, 32'h1);
        wb_io(1'b0, A_STAT, 32'h0);
        `CHK("range", 1'b1, q[S_RANGE])
        `CHK("requests", old, nreq)
        bad <= 1'b1;
        load(8'd0);
        wb_io(1'b0, A_IST, 32'h0);
        `CHK("ist", 32'h2, q)
        $display("test refusals done");
        // byte lanes: only the two low bytes of the target may change
        sel = 4'h3;
        wb_io(1'b1, A_TARGET, 32'h5555_aaaa);
        sel = 4'hf;
        wb_io(1'b0, A_TARGET, 32'h0);
        `CHK("lanes", 32'h00c4_aaaa, q)
        `CHK("rack slot", 32'h00c4_aaaa, {cb_loc, rs_id})
        $display("test lanes done");
        final_report();
    end
endmodule
